/* shared/swd_map.svh */
`ifndef SWD_MAP_SVH
`define SWD_MAP_SVH

// Window offset width (offset bits 14..0)
`define SWD_OFS_W 15
// Base of the 32KB memory window held in BAR0 (bits 31..15 decode)
`define SWD_MEM_BASE_LSB 15
// I/O pointer space at BAR1 is 8 bytes
`define SWD_IO_BASE_LSB 3
// Region boundaries, byte offsets inside the window
`define SWD_MSG_LO 15'h0000
`define SWD_MSG_HI 15'h03ff
`define SWD_OPS_LO 15'h0400
`define SWD_OPS_HI 15'h07ff
`define SWD_RSV_LO 15'h0800
`define SWD_RSV_HI 15'h1fff
`define SWD_DIR_LO 15'h2000
`define SWD_DIR_HI 15'h3fff
`define SWD_SHM_LO 15'h4000
`define SWD_SHM_HI 15'h7fff
// Reset value of chip select polarity: 0 means active low
`define SWD_CS_POL_RST 1'b0

`endif

/* shared/swd_pkg.sv */
`default_nettype none
package swd_pkg;
    typedef enum logic [5:0] {
        SWD_RGN_NONE = 6'h01,
        SWD_RGN_MSG = 6'h02,
        SWD_RGN_OPS = 6'h04,
        SWD_RGN_RSV = 6'h08,
        SWD_RGN_DIR = 6'h10,
        SWD_RGN_SHM = 6'h20
    } swd_region_t;
endpackage
`default_nettype wire

/* src/swd_decoder.sv */
// How it works
// - PCI memory offset taken relative to BAR0
// - Local accesses decoded only under chip select
// - PCI I/O pointers at BAR1 reach map
// - 32KB window: messages, operations, shared memory
// - Serial clock pin only ever driven low
// - Serial data driven low and sampled
// - Select polarity programmable, low after reset
`timescale 1ns/100ps
`default_nettype none
`include "swd_map.svh"
module swd_decoder
    import swd_pkg::*;
(
    input wire logic clock,
    input wire logic reset_n,
    input wire logic pci_mem_req,
    input wire logic [31:0] pci_addr,
    input wire logic [31:0] bar0,
    input wire logic mem_space_en,
    input wire logic pci_io_req,
    input wire logic [31:0] bar1,
    input wire logic io_space_en,
    input wire logic [14:0] io_pointer,
    input wire logic local_req,
    input wire logic [14:0] local_addr,
    input wire logic local_select,
    input wire logic cs_pol_wr,
    input wire logic cs_pol_val,
    input wire logic serial_clk_out,
    input wire logic serial_data_out,
    output logic scl_o,
    output logic scl_oe,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe,
    output logic serial_data_in,
    output logic pci_hit,
    output swd_pkg::swd_region_t pci_region,
    output logic [14:0] pci_offset,
    output logic local_hit,
    output swd_pkg::swd_region_t local_region,
    output logic [14:0] local_offset,
    output logic cs_pol
);
    import swd_pkg::*;

    function automatic swd_region_t region_of(input logic [14:0] ofs,
                                              input logic is_local);
        swd_region_t r;
        r = SWD_RGN_NONE;
        if (ofs <= `SWD_MSG_HI) begin
            r = SWD_RGN_MSG;
        end else if (ofs <= `SWD_OPS_HI) begin
            r = SWD_RGN_OPS;
        end else if (ofs <= `SWD_RSV_HI) begin
            r = SWD_RGN_RSV;
        end else if (ofs <= `SWD_DIR_HI) begin
            r = is_local ? SWD_RGN_DIR : SWD_RGN_RSV;
        end else begin
            r = SWD_RGN_SHM;
        end
        return r;
    endfunction

    logic [31:0] mem_ofs;
    wire logic mem_match;
    wire logic io_match;
    wire logic pci_take;
    wire logic [14:0] pci_ofs_sel;
    wire logic cs_active;
    wire logic local_take;
    logic sda_s;

    // Upper bits compare against the base, the offset is the address minus BAR0
    assign mem_ofs = pci_addr - bar0;
    assign mem_match = pci_mem_req && mem_space_en &&
        (pci_addr[31:`SWD_MEM_BASE_LSB] ==
         bar0[31:`SWD_MEM_BASE_LSB]);
    assign io_match = pci_io_req && io_space_en &&
        (pci_addr[31:`SWD_IO_BASE_LSB] ==
         bar1[31:`SWD_IO_BASE_LSB]);
    assign pci_take = mem_match || io_match;
    // I/O space reaches the map through the pointer value
    assign pci_ofs_sel = io_match ? io_pointer :
        mem_ofs[14:0];
    assign cs_active = (local_select == cs_pol);
    assign local_take = local_req && cs_active;

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            cs_pol <= `SWD_CS_POL_RST;
        end else if (cs_pol_wr) begin
            cs_pol <= cs_pol_val;
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            pci_hit <= 1'b0;
            pci_region <= SWD_RGN_NONE;
            pci_offset <= 15'h0000;
        end else begin
            pci_hit <= pci_take;
            pci_offset <= pci_ofs_sel;
            pci_region <= pci_take ? region_of(pci_ofs_sel, 1'b0)
                : SWD_RGN_NONE;
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            local_hit <= 1'b0;
            local_region <= SWD_RGN_NONE;
            local_offset <= 15'h0000;
        end else begin
            local_hit <= local_take;
            local_offset <= local_addr;
            local_region <= local_take ? region_of(local_addr, 1'b1)
                : SWD_RGN_NONE;
        end
    end

    // Open-collector pins: output data is always 0, enable pulls low
    assign scl_o = 1'b0;
    assign scl_oe = !serial_clk_out;
    assign sda_o = 1'b0;
    assign sda_oe = !serial_data_out;

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            sda_s <= 1'b1;
            serial_data_in <= 1'b1;
        end else begin
            sda_s <= sda_i;
            serial_data_in <= sda_s;
        end
    end

    a_pci_no_direct: assert property (@(posedge clock) disable iff (!reset_n)
        pci_region != SWD_RGN_DIR)
        else $error("PCI side decoded into direct window");
    a_local_needs_cs: assert property (@(posedge clock)
        disable iff (!reset_n)
        local_hit |-> $past(local_req && local_select == cs_pol))
        else $error("local hit without chip select");
    a_local_direct: assert property (@(posedge clock) disable iff (!reset_n)
        (local_req && cs_active && local_addr[14:13] == 2'b01)
        |=> local_region == SWD_RGN_DIR)
        else $error("local direct window not decoded");
    a_shm_region: assert property (@(posedge clock) disable iff (!reset_n)
        (mem_match && !io_match && mem_ofs[14]) |=>
        pci_region == SWD_RGN_SHM && pci_hit)
        else $error("shared memory not decoded");
    a_msg_region: assert property (@(posedge clock) disable iff (!reset_n)
        (local_take && local_addr[14:10] == 5'h00) |=>
        local_region == SWD_RGN_MSG)
        else $error("message region not decoded");
    a_mem_base: assert property (@(posedge clock) disable iff (!reset_n)
        pci_hit && !$past(io_match) |->
        $past(pci_addr[31:15] == bar0[31:15] && pci_mem_req))
        else $error("memory hit outside BAR0 window");
    a_io_pointer: assert property (@(posedge clock) disable iff (!reset_n)
        io_match |=> pci_hit && pci_offset == $past(io_pointer))
        else $error("I/O pointer not used as offset");
    a_scl_low_only: assert property (@(posedge clock) disable iff (!reset_n)
        !serial_clk_out |-> scl_oe && !scl_o)
        else $error("serial clock not pulled low");
    a_sda_sample: assert property (@(posedge clock) disable iff (!reset_n)
        ##2 serial_data_in == $past(sda_i, 2))
        else $error("serial data sample lost");
    a_cs_pol_reset: assert property (@(posedge clock) disable iff (!reset_n)
        $rose(reset_n) |-> !cs_pol)
        else $error("select polarity not low after reset");

    // Request steps and the decode that must follow one cycle later
    sequence s_local_shm_req;
        local_take && local_addr[14];
    endsequence
    sequence s_local_shm_ans;
        local_hit && local_region == SWD_RGN_SHM;
    endsequence
    sequence s_pci_gap_req;
        pci_take && pci_ofs_sel >= `SWD_RSV_LO &&
            pci_ofs_sel <= `SWD_DIR_HI;
    endsequence
    sequence s_pci_gap_ans;
        pci_hit && pci_region == SWD_RGN_RSV;
    endsequence
    sequence s_ops_req;
        local_take && local_addr[14:10] == 5'h01;
    endsequence

    a_local_shm: assert property (@(posedge clock) disable iff (!reset_n)
        s_local_shm_req |=> s_local_shm_ans)
        else $error("local shared memory not decoded");
    a_pci_gap_rsv: assert property (@(posedge clock)
        disable iff (!reset_n)
        s_pci_gap_req |=> s_pci_gap_ans)
        else $error("PCI gap or direct window not reserved");
    a_ops_region: assert property (@(posedge clock) disable iff (!reset_n)
        s_ops_req |=> local_region == SWD_RGN_OPS)
        else $error("operations region not decoded");
    a_local_idle: assert property (@(posedge clock) disable iff (!reset_n)
        !local_take |=> !local_hit && local_region == SWD_RGN_NONE)
        else $error("local decode without request");
    a_local_offset: assert property (@(posedge clock)
        disable iff (!reset_n)
        local_take |=> local_offset == $past(local_addr))
        else $error("local offset not carried");
    a_mem_disabled: assert property (@(posedge clock)
        disable iff (!reset_n)
        (!pci_io_req && !mem_space_en) |=> !pci_hit)
        else $error("memory hit while space disabled");
    a_scl_release: assert property (@(posedge clock) disable iff (!reset_n)
        serial_clk_out |-> !scl_oe)
        else $error("serial clock held low");
    a_sda_low_only: assert property (@(posedge clock)
        disable iff (!reset_n)
        (!serial_data_out |-> sda_oe && !sda_o) and
        (serial_data_out |-> !sda_oe))
        else $error("serial data not open collector");
    a_cs_pol_load: assert property (@(posedge clock)
        disable iff (!reset_n)
        cs_pol_wr |=> cs_pol == $past(cs_pol_val))
        else $error("select polarity not loaded");
endmodule
`default_nettype wire

/* verif/swd_serial_mem.sv */
`timescale 1ns/100ps
`default_nettype none
module swd_serial_mem (
    input wire logic scl_oe,
    input wire logic sda_oe,
    input wire logic mem_pull,
    output logic scl_line,
    output logic sda_line
);
    // Pull-ups lift both lines unless a party sinks them
    assign scl_line = !scl_oe;
    assign sda_line = !(sda_oe || mem_pull);
endmodule
`default_nettype wire

/* verif/tb_swd_decoder.sv */
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin n_mismatch++; \
    $display("[FAIL] %0t got %h exp %h", $time, a, e); end end
module tb_swd_decoder;
    import swd_pkg::*;
    // Every input starts at a defined level
    logic clock = 0, reset_n = 0, pci_mem_req = 0, mem_space_en = 0;
    logic pci_io_req = 0, io_space_en = 0, local_req = 0, local_select = 1;
    logic cs_pol_wr = 0, cs_pol_val = 0, serial_clk_out = 1;
    logic serial_data_out = 1, mem_pull = 0, scl_line;
    logic [31:0] pci_addr = 0, bar0 = 32'h0001_8000, bar1 = 32'h0000_1000;
    logic [14:0] io_pointer = 0, local_addr = 0, pci_offset, local_offset;
    logic scl_o, scl_oe, sda_i, sda_o, sda_oe, serial_data_in, pci_hit;
    logic local_hit, cs_pol;
    swd_region_t pci_region, local_region;
    logic [14:0] ofs [10] = '{15'h0000, 15'h03ff, 15'h0400, 15'h07ff,
        15'h0800, 15'h1fff, 15'h2000, 15'h3fff, 15'h4000, 15'h7fff};
    int n_mismatch = 0, checks = 0;
    swd_decoder dut_u (.clock(clock), .reset_n(reset_n),
        .pci_mem_req(pci_mem_req), .pci_addr(pci_addr), .bar0(bar0),
        .mem_space_en(mem_space_en), .pci_io_req(pci_io_req), .bar1(bar1),
        .io_space_en(io_space_en), .io_pointer(io_pointer),
        .local_req(local_req), .local_addr(local_addr),
        .local_select(local_select), .cs_pol_wr(cs_pol_wr),
        .cs_pol_val(cs_pol_val), .serial_clk_out(serial_clk_out),
        .serial_data_out(serial_data_out), .scl_o(scl_o), .scl_oe(scl_oe),
        .sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe),
        .serial_data_in(serial_data_in), .pci_hit(pci_hit),
        .pci_region(pci_region), .pci_offset(pci_offset),
        .local_hit(local_hit), .local_region(local_region),
        .local_offset(local_offset), .cs_pol(cs_pol));
    swd_serial_mem mem_u (.scl_oe(scl_oe), .sda_oe(sda_oe),
        .mem_pull(mem_pull), .scl_line(scl_line), .sda_line(sda_i));
    always #20 clock = !clock;
    function automatic swd_region_t rg(input logic [14:0] o, input logic l);
        if (o < 15'h0400) return SWD_RGN_MSG;
        if (o < 15'h0800) return SWD_RGN_OPS;
        if (o < 15'h2000 || (o < 15'h4000 && !l)) return SWD_RGN_RSV;
        return (o < 15'h4000) ? SWD_RGN_DIR : SWD_RGN_SHM;
    endfunction
    task loc(input logic [14:0] a, input logic sel, input logic hit);
        @(posedge clock);
        local_req <= 1;
        local_addr <= a;
        local_select <= sel;
        @(posedge clock);
        #1;
        `CHK(local_hit, hit)
        `CHK(local_region, hit ? rg(a, 1) : SWD_RGN_NONE)
        if (hit) `CHK(local_offset, a)
    endtask
    task pci(input logic [31:0] a, input logic en);
        logic hit;
        hit = en && a[31:15] == bar0[31:15];
        @(posedge clock);
        pci_mem_req <= 1;
        mem_space_en <= en;
        pci_addr <= a;
        @(posedge clock);
        #1;
        `CHK(pci_hit, hit)
        if (hit) `CHK({pci_region, pci_offset}, {rg(a[14:0], 0), a[14:0]})
    endtask
    task io(input logic [31:0] a, input logic hit);
        @(posedge clock);
        pci_mem_req <= 0;
        pci_io_req <= 1;
        io_space_en <= 1;
        pci_addr <= a;
        io_pointer <= 15'h0456;
        @(posedge clock);
        #1;
        `CHK(pci_hit, hit)
        if (hit) `CHK({pci_region, pci_offset}, {SWD_RGN_OPS, 15'h0456})
    endtask
    task ser(input logic [2:0] d, input logic [6:0] e);
        @(posedge clock);
        {serial_clk_out, serial_data_out, mem_pull} <= d;
        repeat (3) @(posedge clock);
        #1;
        `CHK({scl_o, sda_o, scl_line, scl_oe, sda_oe, sda_i, serial_data_in}, e)
    endtask
    task summarize;
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    initial begin
        #2000000;
        n_mismatch++;
        summarize;
    end
    initial begin
        repeat (8) @(posedge clock);
        reset_n <= 1;
        #1;
        `CHK(cs_pol, 1'b0)
        foreach (ofs[i]) loc(ofs[i], 0, 1);
        loc(15'h4010, 1, 0);
        $display("local map done");
        foreach (ofs[i]) pci(bar0 + ofs[i], 1);
        pci(32'h0002_4000, 1);
        pci(bar0, 0);
        $display("pci memory done");
        io(bar1 + 4, 1);
        io(bar1 + 8, 0);
        $display("pci io done");
        @(posedge clock);
        pci_io_req <= 0;
        cs_pol_wr <= 1;
        cs_pol_val <= 1;
        @(posedge clock);
        cs_pol_wr <= 0;
        loc(15'h0010, 1, 1);
        loc(15'h0010, 0, 0);
        `CHK(cs_pol, 1'b1)
        $display("select polarity done");
        ser(3'b000, 7'b0001100);
        ser(3'b110, 7'b0010011);
        ser(3'b111, 7'b0010000);
        $display("serial pins done");
        summarize;
    end
endmodule
`default_nettype wire
